// *** verilog/sld_pkg.sv ***
// Shared types and constants for the serial-in latched driver logic.
// Assumes one core clock; all controller pins arrive asynchronously.
package sld_pkg;
	localparam int unsigned SLD_STAGES      = 8;
	localparam int unsigned SLD_FIFO_DEPTH  = 4;
	localparam int unsigned SLD_SYNC_STAGES = 3;

	typedef struct packed {
		logic sdata;
		logic sclk;
		logic strobe;
		logic oe_n;
	} sld_pins_t;

	// One shifted bit travelling from the pin sampler to the register
	typedef struct packed {
		logic data;
	} sld_word_t;

	localparam sld_pins_t SLD_PINS_RST = '{sdata: 1'h0, sclk: 1'h0, strobe: 1'h0, oe_n: 1'h1};
	localparam logic [SLD_STAGES-1:0] SLD_STAGES_RST = 8'h00;
endpackage

// *** verilog/sld_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module sld_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("sld_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wptr_q;
	logic [AW:0]      rptr_q;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign empty     = (wptr_q == rptr_q);
	assign full      = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) && (wptr_q[AW] != rptr_q[AW]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && !full;
	assign pop       = out_ready && !empty;
	assign out_data  = mem_q[rptr_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push)
			mem_q[wptr_q[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wptr_q <= '0;
		end else if (push) begin
			wptr_q <= wptr_q + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rptr_q <= '0;
		end else if (pop) begin
			rptr_q <= rptr_q + (AW+1)'(1);
		end
	end
endmodule // sld_fifo

// *** verilog/sld_driver.sv ***
// Serial-in, parallel-out shift register with transparent latches and output gate.
// Assumes controller pins are asynchronous to CORE_CLK and toggle far slower than it.
`timescale 1ns/1ns
// Behaviour
// - A rising shift-clock edge loads the serial data bit into the first stage once SHIFT_HOLD is low; with the buffer full the bit is lost.
// - Each further rising shift-clock edge moves every stored bit one stage toward the cascade output.
// - While latch-load is high each of the 8 latches takes its matching stage.
// - The latches stay transparent and follow new shifted values while latch-load stays high.
// - With the output gate low each driver output follows its latch.
// - With the output gate high all eight driver outputs are low.
// - The output gate never alters shift register or latch contents.
module sld_driver
	import sld_pkg::*;
#(
	parameter int unsigned STAGES     = SLD_STAGES,
	parameter int unsigned FIFO_DEPTH = SLD_FIFO_DEPTH
) (
	input  wire logic              CORE_CLK,
	input  wire logic              ARST_N,
	input  wire logic              SER_DATA,
	input  wire logic              SHIFT_CLK,
	input  wire logic              LATCH_LOAD,
	input  wire logic              OUT_GATE_N,
	input  wire logic              SHIFT_HOLD,
	output logic                   SHIFT_READY,
	output logic      [STAGES-1:0] DRV_OUT,
	output logic                   CASCADE_OUT
);
	import sld_pkg::*;

	initial begin
		if (STAGES < 2)
			$error("sld_driver: STAGES must be at least 2");
		if (FIFO_DEPTH < 2)
			$error("sld_driver: FIFO_DEPTH must be at least 2");
	end

	sld_pins_t         pins_raw;
	sld_pins_t         sync_q [SLD_SYNC_STAGES];
	sld_pins_t         filt_q;
	sld_word_t         push_word;
	sld_word_t         pop_word;
	logic              push_valid;
	logic              push_ready;
	logic              pop_valid;
	logic              pop_ready;
	logic [STAGES-1:0] shreg_q;
	logic [STAGES-1:0] latch_q;
	logic [STAGES-1:0] drv_q;
	logic              cascade_q;

	assign pins_raw = '{sdata: SER_DATA, sclk: SHIFT_CLK, strobe: LATCH_LOAD, oe_n: OUT_GATE_N};

	// Three-stage synchroniser; stage 0 feeds only stage 1
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < SLD_SYNC_STAGES; i++)
				sync_q[i] <= SLD_PINS_RST;
		end else begin
			sync_q[0] <= pins_raw;
			for (int i = 1; i < SLD_SYNC_STAGES; i++)
				sync_q[i] <= sync_q[i-1];
		end
	end

	// Accept a pin change only once stages two and three agree
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			filt_q <= SLD_PINS_RST;
		end else begin
			if (sync_q[1].sclk == sync_q[2].sclk)
				filt_q.sclk <= sync_q[2].sclk;
			if (sync_q[1].sdata == sync_q[2].sdata)
				filt_q.sdata <= sync_q[2].sdata;
			if (sync_q[1].strobe == sync_q[2].strobe)
				filt_q.strobe <= sync_q[2].strobe;
			if (sync_q[1].oe_n == sync_q[2].oe_n)
				filt_q.oe_n <= sync_q[2].oe_n;
		end
	end

	// Data comes from the filter stage, one cycle behind the clock edge detect, so set-up before the edge carries through
	assign push_valid     = (sync_q[1].sclk == sync_q[2].sclk) && sync_q[2].sclk && !filt_q.sclk;
	assign push_word.data = filt_q.sdata;
	assign pop_ready      = !SHIFT_HOLD;
	// Bits arriving while full are dropped; the controller must watch this
	assign SHIFT_READY    = push_ready;

	sld_fifo #(
		.WIDTH ($bits(sld_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CORE_CLK),
		.arst_n    (ARST_N),
		.in_data   (push_word),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.out_data  (pop_word),
		.out_valid (pop_valid),
		.out_ready (pop_ready)
	);

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			shreg_q <= STAGES'(SLD_STAGES_RST);
		end else if (pop_valid && pop_ready) begin
			shreg_q <= {shreg_q[STAGES-2:0], pop_word.data};
		end
	end

	// Latch follows the register while load is high, holds otherwise
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			latch_q <= STAGES'(SLD_STAGES_RST);
		end else if (filt_q.strobe) begin
			latch_q <= shreg_q;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			drv_q <= STAGES'(SLD_STAGES_RST);
		end else if (filt_q.oe_n) begin
			drv_q <= '0;
		end else begin
			drv_q <= latch_q;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cascade_q <= 1'h0;
		end else begin
			cascade_q <= shreg_q[STAGES-1];
		end
	end

	assign DRV_OUT     = drv_q;
	assign CASCADE_OUT = cascade_q;
endmodule // sld_driver

// *** verification/sld_driver_chk.sv ***
// Port checker for sld_driver.
// Assumes pins hold each level for several core cycles.
`timescale 1ns/1ns
module sld_driver_chk #(
	parameter int unsigned STAGES = 8
) (
	input wire logic		CORE_CLK,
	input wire logic		ARST_N,
	input wire logic		SER_DATA,
	input wire logic		SHIFT_CLK,
	input wire logic		LATCH_LOAD,
	input wire logic		OUT_GATE_N,
	input wire logic		SHIFT_HOLD,
	input wire logic		SHIFT_READY,
	input wire logic [STAGES-1:0]	DRV_OUT,
	input wire logic		CASCADE_OUT
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	// Windows of 6 to 8 cycles cover the pin filter delay
	a_gate_blanks: assert property (OUT_GATE_N[*6] |-> DRV_OUT == '0) else $error("gated output on");
	a_gate_off: assert property ($rose(OUT_GATE_N) |-> ##[1:6] DRV_OUT == '0) else $error("slow blanking");
	a_latch_hold: assert property ((!LATCH_LOAD && !OUT_GATE_N)[*8] |-> $stable(DRV_OUT))
		else $error("closed latch moved");
	a_cascade_last: assert property ((LATCH_LOAD && !OUT_GATE_N && !SHIFT_CLK && !SHIFT_HOLD)[*8]
		|-> DRV_OUT[STAGES-1] == CASCADE_OUT) else $error("cascade differs from last stage");
	a_cascade_still: assert property ((!SHIFT_CLK && !SHIFT_HOLD)[*8] |-> $stable(CASCADE_OUT))
		else $error("shift without clock");
	a_bit_enters: assert property ($rose(SHIFT_CLK) ##0 (LATCH_LOAD && !OUT_GATE_N && !SHIFT_HOLD
		&& $stable(SER_DATA))[*8] |-> DRV_OUT[0] == SER_DATA) else $error("first stage missed");
	a_ready_idle: assert property (!SHIFT_HOLD[*8] |-> SHIFT_READY) else $error("buffer not drained");
	a_reset_quiet: assert property ($rose(ARST_N) |-> DRV_OUT == '0 && !CASCADE_OUT && SHIFT_READY)
		else $error("bad reset state");
endmodule // sld_driver_chk
bind sld_driver sld_driver_chk #(.STAGES(STAGES)) u_chk (.CORE_CLK, .ARST_N, .SER_DATA, .SHIFT_CLK,
	.LATCH_LOAD, .OUT_GATE_N, .SHIFT_HOLD, .SHIFT_READY, .DRV_OUT, .CASCADE_OUT);

// *** verification/sld_ctrl_model.sv ***
// Controller model driving data, shift clock, latch-load and gate.
// Changes pins just after CORE_CLK rises.
`timescale 1ns/1ns
module sld_ctrl_model (
	input wire logic	clk,
	output logic		sdata,
	output logic		sclk,
	output logic		load,
	output logic		gate_n
);
	initial {sdata, sclk, load, gate_n} = 4'h1;
	task automatic pins(input logic l, input logic g);
		@(posedge clk) {load, gate_n} <= {l, g};
		repeat (8) @(posedge clk);
	endtask
	// Data held through the whole high phase, beyond the filter's need
	task automatic send(input logic [7:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk) sdata <= v[i];
			repeat (4) @(posedge clk);
			sclk <= 1'h1;
			repeat (8) @(posedge clk);
			sclk <= 1'h0;
			repeat (4) @(posedge clk);
		end
	endtask
endmodule // sld_ctrl_model

// *** verification/sld_driver_bench.sv ***
// Self-checking bench for sld_driver.
// Controller model drives the pins; the bench drives SHIFT_HOLD.
`timescale 1ns/1ns
module sld_driver_bench;
	logic		clk = 1'h0;
	logic		rst_n = 1'h0;
	logic		hold = 1'h0;
	logic		sd, sc, ld, gn, rdy, cas;
	logic [7:0]	drv;
	int		num_errors = 0;
	int		total_checks = 0;
	initial forever #2 clk = ~clk;
	sld_ctrl_model ctl (.clk(clk), .sdata(sd), .sclk(sc), .load(ld), .gate_n(gn));
	sld_driver DUT (.CORE_CLK(clk), .ARST_N(rst_n), .SER_DATA(sd), .SHIFT_CLK(sc), .LATCH_LOAD(ld),
		.OUT_GATE_N(gn), .SHIFT_HOLD(hold), .SHIFT_READY(rdy), .DRV_OUT(drv), .CASCADE_OUT(cas));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_latch();
		ctl.pins(1'h0, 1'h0);
		ctl.send(8'ha5, 8);
		chk(drv, 8'h00);
		chk(8'(cas), 8'h01);
		ctl.pins(1'h1, 1'h0);
		ctl.pins(1'h0, 1'h0);
		chk(drv, 8'ha5);
		$display("latch test done");
	endtask
	task automatic t_gate();
		ctl.pins(1'h0, 1'h1);
		chk(drv, 8'h00);
		ctl.send(8'h3c, 8);
		ctl.pins(1'h0, 1'h0);
		chk(drv, 8'ha5);
		ctl.pins(1'h1, 1'h0);
		chk(drv, 8'h3c);
		$display("gate test done");
	endtask
	task automatic t_follow();
		ctl.pins(1'h1, 1'h1);
		ctl.send(8'h96, 8);
		ctl.pins(1'h1, 1'h0);
		chk(drv, 8'h96);
		$display("follow test done");
	endtask
	// Fifth bit meets a full buffer and is lost
	task automatic t_fifo();
		hold <= 1'h1;
		ctl.send(8'h0f, 4);
		chk(8'(rdy), 8'h00);
		ctl.send(8'h00, 1);
		hold <= 1'h0;
		ctl.send(8'h01, 1);
		chk(drv, 8'hdf);
		$display("fifo test done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		t_latch();
		t_gate();
		t_follow();
		t_fifo();
		test_done();
	end
	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		test_done();
	end
endmodule // sld_driver_bench
